// ### rtl/sls_compare.sv
// Limit comparison for all compare modes; pure combinational.
// Assumes signed values; the hysteresis width is non-negative.
`timescale 1ns/1ps
`default_nettype none
module sls_compare #(
  parameter int DW = 32
) (
  // Configuration
  input  wire logic [2:0]    i_mode,
  input  wire logic [DW-1:0] i_low,
  input  wire logic [DW-1:0] i_high,
  input  wire logic [DW-1:0] i_hyst,
  // Operands
  input  wire logic [DW-1:0] i_value,
  input  wire logic          i_prev,
  // Result
  output logic               o_cond
);
  // Two guard bits keep abs and limit+hyst/2 from overflowing
  logic signed [DW+1:0] val;
  logic signed [DW+1:0] low;
  logic signed [DW+1:0] high;
  logic signed [DW+1:0] half;
  logic signed [DW+1:0] abs_val;
  logic signed [DW+1:0] abs_low;
  logic signed [DW+1:0] abs_high;
  logic signed [DW+1:0] thr_on;
  logic signed [DW+1:0] thr_off;

  assign val      = {{2{i_value[DW-1]}}, i_value};
  assign low      = {{2{i_low[DW-1]}}, i_low};
  assign high     = {{2{i_high[DW-1]}}, i_high};
  assign half     = {3'h0, i_hyst[DW-1:1]};
  assign abs_val  = val[DW+1] ? -val : val;
  assign abs_low  = low[DW+1] ? -low : low;
  assign abs_high = high[DW+1] ? -high : high;
  assign thr_on   = high + half;
  assign thr_off  = high - half;

  always_comb begin
    case (i_mode)
      sls_pkg::MODE_LOW:      o_cond = val < low; // R02
      sls_pkg::MODE_HIGH:     o_cond = val > high; // R03
      sls_pkg::MODE_ABS_LOW:  o_cond = abs_val < abs_low; // R04
      sls_pkg::MODE_ABS_HIGH: o_cond = abs_val > abs_high; // R05
      sls_pkg::MODE_BOTH:     o_cond = (val < low) || (val > high); // R06
      sls_pkg::MODE_ABS_BOTH: o_cond = (abs_val < abs_low) || (abs_val > abs_high); // R07
      // Latch on above the upper band edge, release only below the lower edge
      sls_pkg::MODE_HYST:     o_cond = i_prev ? !(val < thr_off) : (val > thr_on); // R08
      default:                o_cond = 1'b0;
    endcase
  end
endmodule : sls_compare
`default_nettype wire

// ### rtl/sls_pkg.sv
// Constants of the signal limit supervisor: register map, field layout, codes.
// Assumes a 32-bit register port with word indices and 32-bit signed signals.
package sls_pkg;
  localparam int DW = 32;
  localparam int AW = 4;
  // Register indices
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_LOW    = 4'h1;
  localparam logic [3:0] ADDR_HIGH   = 4'h2;
  localparam logic [3:0] ADDR_HYST   = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_EVENT  = 4'h5;
  localparam logic [3:0] ADDR_MASK   = 4'h6;
  // Control word fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACT_LSB  = 4;
  localparam int CTRL_SIG_LSB  = 8;
  localparam int MODE_W = 3;
  localparam int ACT_W  = 2;
  localparam int SIG_W  = 5;
  // Event bits
  localparam int EVT_W    = 2;
  localparam int EVT_WARN = 0;
  localparam int EVT_FLT  = 1;
  // Compare modes
  localparam logic [2:0] MODE_OFF      = 3'h0;
  localparam logic [2:0] MODE_LOW      = 3'h1;
  localparam logic [2:0] MODE_HIGH     = 3'h2;
  localparam logic [2:0] MODE_ABS_LOW  = 3'h3;
  localparam logic [2:0] MODE_ABS_HIGH = 3'h4;
  localparam logic [2:0] MODE_BOTH     = 3'h5;
  localparam logic [2:0] MODE_ABS_BOTH = 3'h6;
  localparam logic [2:0] MODE_HYST     = 3'h7;
  // Actions
  localparam logic [1:0] ACT_NONE    = 2'h0;
  localparam logic [1:0] ACT_WARN    = 2'h1;
  localparam logic [1:0] ACT_FAULT   = 2'h2;
  localparam logic [1:0] ACT_FLT_RUN = 2'h3;
  // Event codes reported with warning and fault
  localparam logic [15:0] WARN_CODE  = 16'hA8B0;
  localparam logic [15:0] FAULT_CODE = 16'h80B0;
  // Signal selection
  localparam logic [4:0] SIG_ZERO  = 5'h00;
  localparam logic [4:0] SIG_SPEED = 5'h01;
  localparam logic [4:0] SIG_FREQ  = 5'h03;
  localparam logic [4:0] SIG_CURR  = 5'h04;
  localparam logic [4:0] SIG_TORQ  = 5'h06;
  localparam logic [4:0] SIG_DCV   = 5'h07;
  localparam logic [4:0] SIG_POWER = 5'h08;
  localparam logic [4:0] SIG_AI1   = 5'h09;
  localparam logic [4:0] SIG_AI2   = 5'h0A;
  localparam logic [4:0] SIG_RAMP  = 5'h12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0300;
endpackage : sls_pkg

// ### rtl/sls_signal_mux.sv
// Picks the monitored quantity by the signal-select code.
// Assumes all quantities are signed words on the system clock.
`timescale 1ns/1ps
`default_nettype none
module sls_signal_mux #(
  parameter int DW = 32
) (
  // Selection
  input  wire logic [4:0]    i_sel,
  // Quantities
  input  wire logic [DW-1:0] i_speed,
  input  wire logic [DW-1:0] i_freq,
  input  wire logic [DW-1:0] i_current,
  input  wire logic [DW-1:0] i_torque,
  input  wire logic [DW-1:0] i_dc_voltage,
  input  wire logic [DW-1:0] i_power,
  input  wire logic [DW-1:0] i_analogue_input_one,
  input  wire logic [DW-1:0] i_analogue_input_two,
  input  wire logic [DW-1:0] i_ramp_in,
  // Result
  output logic      [DW-1:0] o_value
);
  // Zero and reserved codes give a zero value
  always_comb begin
    case (i_sel)
      sls_pkg::SIG_SPEED: o_value = i_speed;
      sls_pkg::SIG_FREQ:  o_value = i_freq;
      sls_pkg::SIG_CURR:  o_value = i_current;
      sls_pkg::SIG_TORQ:  o_value = i_torque;
      sls_pkg::SIG_DCV:   o_value = i_dc_voltage;
      sls_pkg::SIG_POWER: o_value = i_power;
      sls_pkg::SIG_AI1:   o_value = i_analogue_input_one;
      sls_pkg::SIG_AI2:   o_value = i_analogue_input_two;
      sls_pkg::SIG_RAMP:  o_value = i_ramp_in;
      default:            o_value = '0;
    endcase
  end
endmodule : sls_signal_mux
`default_nettype wire

// ### rtl/sls_supervisor.sv
// One signal-supervision channel: registers, update on tick, actions, interrupt.
// Assumes the quantities, tick and running flag are on i_clk_sys already.
//
// What this block does
// (R01) Compare mode 0 disables supervision; no condition, no action.
// (R02) Mode 1: condition while signal below lower limit.
// (R03) Mode 2: condition while signal above upper limit.
// (R04) Mode 3: condition while absolute signal below absolute lower limit.
// (R05) Mode 4: condition while absolute signal above absolute upper limit.
// (R06) Mode 5: condition while signal below low or above high limit.
// (R07) Mode 6: absolute signal below absolute low or above absolute high.
// (R08) Mode 7: set above limit plus half hysteresis, clear below limit minus half.
// (R09) Action 0 does nothing; action 1 raises warning A8B0 while condition holds.
// (R10) Action 2 trips fault 80B0; action 3 trips it only while running.
// (R11) Active status follows the condition whatever the action setting.
// (R12) Signal select picks the monitored quantity; reserved codes read zero.
// (R13) Status bit 0 reads 1 while the signal is outside its limits.
// (R14) Comparison re-evaluated on each tick with current signal, mode, limits.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sls_supervisor #(
  parameter int DW = 32
) (
  // Clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst,
  // Register port
  input  wire logic [3:0]    i_addr,
  input  wire logic [31:0]   i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [31:0]   o_rdata,
  // Drive state
  input  wire logic          i_tick,
  input  wire logic          i_running,
  // Monitored quantities
  input  wire logic [DW-1:0] i_speed,
  input  wire logic [DW-1:0] i_freq,
  input  wire logic [DW-1:0] i_current,
  input  wire logic [DW-1:0] i_torque,
  input  wire logic [DW-1:0] i_dc_voltage,
  input  wire logic [DW-1:0] i_power,
  input  wire logic [DW-1:0] i_analogue_input_one,
  input  wire logic [DW-1:0] i_analogue_input_two,
  input  wire logic [DW-1:0] i_ramp_in,
  // Results
  output logic               o_active,
  output logic               o_warning,
  output logic               o_fault,
  output logic      [15:0]   o_event_code,
  output logic               o_irq
);
  logic [31:0]             ctrl;
  logic [DW-1:0]           low_lim;
  logic [DW-1:0]           high_lim;
  logic [DW-1:0]           hyst;
  logic [1:0]              evt;
  logic [1:0]              mask;
  logic                    active;
  logic                    warning;
  logic                    fault;
  logic [15:0]             event_code;
  logic                    irq;
  logic [31:0]             rdata;

  wire [2:0]    mode   = ctrl[sls_pkg::CTRL_MODE_LSB +: sls_pkg::MODE_W];
  wire [1:0]    action = ctrl[sls_pkg::CTRL_ACT_LSB +: sls_pkg::ACT_W];
  wire [4:0]    sig    = ctrl[sls_pkg::CTRL_SIG_LSB +: sls_pkg::SIG_W];
  wire [DW-1:0] value;
  wire          cond;

  // Register decode
  wire wr_ctrl  = i_wr && (i_addr == sls_pkg::ADDR_CTRL);
  wire wr_low   = i_wr && (i_addr == sls_pkg::ADDR_LOW);
  wire wr_high  = i_wr && (i_addr == sls_pkg::ADDR_HIGH);
  wire wr_hyst  = i_wr && (i_addr == sls_pkg::ADDR_HYST);
  wire wr_event = i_wr && (i_addr == sls_pkg::ADDR_EVENT);
  wire wr_mask  = i_wr && (i_addr == sls_pkg::ADDR_MASK);

  sls_signal_mux #(
    .DW (DW)
  ) u_mux (
    .i_sel                (sig),                  // R12
    .i_speed              (i_speed),
    .i_freq               (i_freq),
    .i_current            (i_current),
    .i_torque             (i_torque),
    .i_dc_voltage         (i_dc_voltage),
    .i_power              (i_power),
    .i_analogue_input_one (i_analogue_input_one),
    .i_analogue_input_two (i_analogue_input_two),
    .i_ramp_in            (i_ramp_in),
    .o_value              (value)
  );

  sls_compare #(
    .DW (DW)
  ) u_cmp (
    .i_mode  (mode),
    .i_low   (low_lim),
    .i_high  (high_lim),
    .i_hyst  (hyst),
    .i_value (value),
    .i_prev  (active),
    .o_cond  (cond)
  );

  // Next active state, trips and event sets taken on tick only; warning and fault ack act every cycle
  wire next_active  = i_tick ? (cond && (mode != sls_pkg::MODE_OFF)) : active; // R01 R11 R14
  wire warn_now     = next_active && (action == sls_pkg::ACT_WARN);            // R09
  wire trip_now     = next_active && i_tick
                      && ((action == sls_pkg::ACT_FAULT)
                          || ((action == sls_pkg::ACT_FLT_RUN) && i_running)); // R10
  wire [1:0] ev_set = {trip_now, warn_now && i_tick};
  wire [1:0] ev_clr = wr_event ? i_wdata[1:0] : 2'h0;
  // A new event in the clearing cycle survives the clear
  wire [1:0] next_evt = (evt & ~ev_clr) | ev_set;
  // A trip is held until software acknowledges the fault event bit
  wire next_fault = trip_now || (fault && !ev_clr[sls_pkg::EVT_FLT]);        // R10
  wire [15:0] next_code = next_fault ? sls_pkg::FAULT_CODE
                        : (warn_now ? sls_pkg::WARN_CODE : 16'h0000);

  // Read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    case (i_addr)
      sls_pkg::ADDR_CTRL:   rd_mux = ctrl;
      sls_pkg::ADDR_LOW:    rd_mux = low_lim;
      sls_pkg::ADDR_HIGH:   rd_mux = high_lim;
      sls_pkg::ADDR_HYST:   rd_mux = hyst;
      sls_pkg::ADDR_STATUS: rd_mux = {31'h0, active};             // R13
      sls_pkg::ADDR_EVENT:  rd_mux = {30'h0, evt};
      sls_pkg::ADDR_MASK:   rd_mux = {30'h0, mask};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl     <= sls_pkg::CTRL_RESET;
      low_lim  <= '0;
      high_lim <= '0;
      hyst     <= '0;
      mask     <= 2'h0;
    end else begin
      if (wr_ctrl)  ctrl     <= i_wdata;
      if (wr_low)   low_lim  <= i_wdata;
      if (wr_high)  high_lim <= i_wdata;
      if (wr_hyst)  hyst     <= i_wdata;
      if (wr_mask)  mask     <= i_wdata[1:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      active     <= 1'b0;
      warning    <= 1'b0;
      fault      <= 1'b0;
      event_code <= 16'h0000;
      evt        <= 2'h0;
      irq        <= 1'b0;
      rdata      <= 32'h0000_0000;
    end else begin
      active     <= next_active;
      warning    <= warn_now;
      fault      <= next_fault;
      event_code <= next_code;
      evt        <= next_evt;
      irq        <= |(next_evt & mask);
      rdata      <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign o_active     = active;
  assign o_warning    = warning;
  assign o_fault      = fault;
  assign o_event_code = event_code;
  assign o_irq        = irq;
  assign o_rdata      = rdata;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_off;
    i_tick && mode == sls_pkg::MODE_OFF && !wr_ctrl |=> !o_active && !o_warning;
  endproperty
  a_off: assert property (p_off) else $error("disabled channel active"); // R01

  property p_low;
    i_tick && mode == sls_pkg::MODE_LOW && $signed(value) < $signed(low_lim)
      |=> o_active;
  endproperty
  a_low: assert property (p_low) else $error("low mode missed"); // R02

  property p_high;
    i_tick && mode == sls_pkg::MODE_HIGH && $signed(value) <= $signed(high_lim)
      |=> !o_active;
  endproperty
  a_high: assert property (p_high) else $error("high mode false hit"); // R03

  property p_both;
    i_tick && mode == sls_pkg::MODE_BOTH && $signed(value) > $signed(high_lim)
      |=> o_active;
  endproperty
  a_both: assert property (p_both) else $error("both mode missed"); // R06

  property p_hold;
    !i_tick |=> $stable(o_active);
  endproperty
  a_hold: assert property (p_hold) else $error("active moved off tick"); // R14

  property p_warn;
    i_tick && action == sls_pkg::ACT_WARN ##1 o_active |-> o_warning
      && o_event_code == sls_pkg::WARN_CODE;
  endproperty
  a_warn: assert property (p_warn) else $error("warning missing"); // R09

  property p_trip;
    i_tick && cond && mode != sls_pkg::MODE_OFF && action == sls_pkg::ACT_FAULT
      |=> o_fault && o_event_code == sls_pkg::FAULT_CODE ##1 o_irq == mask[1];
  endproperty
  a_trip: assert property (p_trip) else $error("fault not tripped"); // R10

  property p_norun;
    !o_fault && action == sls_pkg::ACT_FLT_RUN && !i_running |=> !$rose(o_fault);
  endproperty
  a_norun: assert property (p_norun) else $error("tripped while stopped"); // R10

  property p_status;
    i_rd && i_addr == sls_pkg::ADDR_STATUS |=> o_rdata[0] == $past(o_active);
  endproperty
  a_status: assert property (p_status) else $error("status bit wrong"); // R13

  property p_sel;
    sig == sls_pkg::SIG_AI2 |-> value == i_analogue_input_two;
  endproperty
  a_sel: assert property (p_sel) else $error("signal select wrong"); // R12

  property p_sel_zero;
    sig == sls_pkg::SIG_ZERO |-> value == '0;
  endproperty
  a_sel_zero: assert property (p_sel_zero) else $error("zero select not zero"); // R12

  property p_low_clr;
    i_tick && mode == sls_pkg::MODE_LOW && $signed(value) >= $signed(low_lim)
      |=> !o_active;
  endproperty
  a_low_clr: assert property (p_low_clr) else $error("low mode false hit"); // R02

  property p_high_set;
    i_tick && mode == sls_pkg::MODE_HIGH && $signed(value) > $signed(high_lim)
      |=> o_active;
  endproperty
  a_high_set: assert property (p_high_set) else $error("high mode missed"); // R03

  // Negative signal against a positive limit: its magnitude is the negation
  property p_abs_low;
    i_tick && mode == sls_pkg::MODE_ABS_LOW && value[DW-1] && !low_lim[DW-1]
      && ($signed(value) + $signed(low_lim) > 0) |=> o_active;
  endproperty
  a_abs_low: assert property (p_abs_low) else $error("abs low mode missed"); // R04

  property p_abs_high;
    i_tick && mode == sls_pkg::MODE_ABS_HIGH && value[DW-1] && !high_lim[DW-1]
      && ($signed(value) + $signed(high_lim) < 0) |=> o_active;
  endproperty
  a_abs_high: assert property (p_abs_high) else $error("abs high mode missed"); // R05

  property p_both_in;
    i_tick && mode == sls_pkg::MODE_BOTH && $signed(value) >= $signed(low_lim)
      && $signed(value) <= $signed(high_lim) |=> !o_active;
  endproperty
  a_both_in: assert property (p_both_in) else $error("both mode false hit"); // R06

  property p_abs_both;
    i_tick && mode == sls_pkg::MODE_ABS_BOTH && value[DW-1] && !high_lim[DW-1]
      && ($signed(value) + $signed(high_lim) < 0) |=> o_active;
  endproperty
  a_abs_both: assert property (p_abs_both) else $error("abs both mode missed"); // R07

  // Two guard bits keep the distance and the half band from wrapping
  wire signed [DW+1:0] over_high = {{2{value[DW-1]}}, value}
                                   - {{2{high_lim[DW-1]}}, high_lim};
  wire signed [DW+1:0] half_hyst = {3'h0, hyst[DW-1:1]};

  property p_hyst_on;
    i_tick && mode == sls_pkg::MODE_HYST && !o_active && over_high > half_hyst
      |=> o_active;
  endproperty
  a_hyst_on: assert property (p_hyst_on) else $error("hysteresis set missed"); // R08

  property p_hyst_low;
    i_tick && mode == sls_pkg::MODE_HYST && !o_active && over_high <= half_hyst
      |=> !o_active;
  endproperty
  a_hyst_low: assert property (p_hyst_low) else $error("hysteresis set early"); // R08

  property p_hyst_keep;
    i_tick && mode == sls_pkg::MODE_HYST && o_active && over_high >= -half_hyst
      |=> o_active;
  endproperty
  a_hyst_keep: assert property (p_hyst_keep) else $error("hysteresis left early"); // R08

  property p_hyst_off;
    i_tick && mode == sls_pkg::MODE_HYST && over_high < -half_hyst
      |=> !o_active;
  endproperty
  a_hyst_off: assert property (p_hyst_off) else $error("hysteresis kept"); // R08

  // Status must not depend on the action setting
  property p_no_action;
    i_tick && action == sls_pkg::ACT_NONE && mode == sls_pkg::MODE_HIGH
      && $signed(value) > $signed(high_lim) |=> o_active && !o_warning;
  endproperty
  a_no_action: assert property (p_no_action) else $error("status tied to action"); // R11

  property p_warn_evt;
    i_tick && action == sls_pkg::ACT_WARN ##1 o_active
      |-> evt[sls_pkg::EVT_WARN];
  endproperty
  a_warn_evt: assert property (p_warn_evt) else $error("warning event not set"); // R09

  property p_run_trip;
    i_tick && action == sls_pkg::ACT_FLT_RUN && i_running && mode == sls_pkg::MODE_HIGH
      && $signed(value) > $signed(high_lim) |=> o_fault;
  endproperty
  a_run_trip: assert property (p_run_trip) else $error("running trip missed"); // R10

  property p_fault_hold;
    o_fault && !(wr_event && i_wdata[sls_pkg::EVT_FLT]) |=> o_fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped"); // R10

  // Mask and clear writes take an edge to show, so only quiet cycles are checked
  property p_irq;
    |(evt & mask) && !wr_event && !wr_mask |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_rdata_idle;
    !i_rd |=> o_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");
endmodule : sls_supervisor
`default_nettype wire

// ### tb/sls_supervisor_tb.sv
// Self-checking bench for the signal limit supervisor channel.
// Assumes the register map and codes of sls_pkg; drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module sls_supervisor_tb;
  typedef struct {
    logic [2:0]  mode;
    logic [1:0]  act;
    logic [4:0]  sig;
    logic [31:0] val;
    logic [31:0] low;
    logic [31:0] high;
    logic        act_exp;
    logic        warn_exp;
    logic        flt_exp;
  } sls_row_type;

  // Unselected quantities sit far negative so a wrong pick changes the outcome
  localparam logic [31:0] OTHER = 32'h8000_1000;

  logic        i_clk_sys;
  logic        i_rst;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        i_tick;
  logic        i_running;
  logic [31:0] q [9];
  logic        o_active;
  logic        o_warning;
  logic        o_fault;
  logic [15:0] o_event_code;
  logic        o_irq;
  int          failures;
  int          total_checks;
  sls_row_type rows [13];

  sls_supervisor #(.DW(32)) i_sls_supervisor (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tick(i_tick),
    .i_running(i_running), .i_speed(q[0]), .i_freq(q[1]), .i_current(q[2]),
    .i_torque(q[3]), .i_dc_voltage(q[4]), .i_power(q[5]),
    .i_analogue_input_one(q[6]), .i_analogue_input_two(q[7]), .i_ramp_in(q[8]),
    .o_active(o_active), .o_warning(o_warning), .o_fault(o_fault),
    .o_event_code(o_event_code), .o_irq(o_irq));

  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
    @(negedge i_clk_sys);
    chk(o_rdata, exp, what);
  endtask : rd_chk

  task automatic set_sig(input logic [4:0] code, input logic [31:0] v);
    int k;
    k = -1;
    case (code)
      sls_pkg::SIG_SPEED: k = 0;
      sls_pkg::SIG_FREQ:  k = 1;
      sls_pkg::SIG_CURR:  k = 2;
      sls_pkg::SIG_TORQ:  k = 3;
      sls_pkg::SIG_DCV:   k = 4;
      sls_pkg::SIG_POWER: k = 5;
      sls_pkg::SIG_AI1:   k = 6;
      sls_pkg::SIG_AI2:   k = 7;
      sls_pkg::SIG_RAMP:  k = 8;
      default:            k = -1;
    endcase
    @(posedge i_clk_sys);
    for (int j = 0; j < 9; j++) q[j] <= (j == k) ? v : OTHER;
  endtask : set_sig

  // Configure, present the value, pulse one tick and let the result land
  task automatic apply(input sls_row_type r);
    wr(sls_pkg::ADDR_LOW, r.low);
    wr(sls_pkg::ADDR_HIGH, r.high);
    wr(sls_pkg::ADDR_CTRL, {19'h0, r.sig, 2'h0, r.act, 1'b0, r.mode});
    set_sig(r.sig, r.val);
    @(posedge i_clk_sys);
    i_tick <= 1'b1;
    @(posedge i_clk_sys);
    i_tick <= 1'b0;
    @(negedge i_clk_sys);
  endtask : apply

  task automatic chk_out(input logic a, input logic w, input logic f);
    chk({31'h0, o_active}, {31'h0, a}, "active");
    chk({31'h0, o_warning}, {31'h0, w}, "warning");
    chk({31'h0, o_fault}, {31'h0, f}, "fault");
    chk({16'h0, o_event_code}, {16'h0, f ? sls_pkg::FAULT_CODE :
        (w ? sls_pkg::WARN_CODE : 16'h0000)}, "event code");
  endtask : chk_out

  task automatic results;
    $display("Checks made %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  initial begin
    #(100ns * 5000);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    failures = 0;
    total_checks = 0;
    i_rst = 1'b1; i_addr = 4'h0; i_wdata = 32'h0; i_wr = 1'b0; i_rd = 1'b0;
    i_tick = 1'b0; i_running = 1'b0;
    for (int j = 0; j < 9; j++) q[j] = OTHER;
    rows = '{
      '{3'h0, 2'h1, 5'h03, 32'hFFFF_FE0C, 32'h0, 32'h0, 0, 0, 0},
      '{3'h1, 2'h1, 5'h01, 32'hFFFF_FFFB, 32'h0, 32'h0, 1, 1, 0},
      '{3'h1, 2'h0, 5'h01, 32'h5, 32'h0, 32'h0, 0, 0, 0},
      '{3'h2, 2'h2, 5'h04, 32'd200, 32'h0, 32'd100, 1, 0, 1},
      '{3'h2, 2'h0, 5'h06, 32'd200, 32'h0, 32'd100, 1, 0, 0},
      '{3'h3, 2'h1, 5'h07, 32'hFFFF_FFFB, 32'd10, 32'h0, 1, 1, 0},
      '{3'h3, 2'h1, 5'h07, 32'hFFFF_FFCE, 32'd10, 32'h0, 0, 0, 0},
      '{3'h4, 2'h2, 5'h08, 32'hFFFF_FF38, 32'h0, 32'd100, 1, 0, 1},
      '{3'h5, 2'h1, 5'h09, 32'd50, 32'hFFFF_FFF6, 32'd20, 1, 1, 0},
      '{3'h5, 2'h1, 5'h0A, 32'h0, 32'hFFFF_FFF6, 32'd20, 0, 0, 0},
      '{3'h6, 2'h1, 5'h12, 32'hFFFF_FFE2, 32'd5, 32'd20, 1, 1, 0},
      '{3'h2, 2'h1, 5'h00, 32'd99, 32'h0, 32'hFFFF_FFFB, 1, 1, 0},
      '{3'h2, 2'h1, 5'h02, 32'd99, 32'h0, 32'hFFFF_FFFB, 1, 1, 0}};
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(negedge i_clk_sys);
    chk_out(1'b0, 1'b0, 1'b0);
    chk({31'h0, o_irq}, 32'h0, "irq after reset");
    chk(o_rdata, 32'h0, "idle read data");
    rd_chk(sls_pkg::ADDR_CTRL, sls_pkg::CTRL_RESET, "control reset");
    rd_chk(sls_pkg::ADDR_LOW, 32'h0, "low reset");
    rd_chk(4'hF, 32'h0, "unmapped read");
    wr(4'hF, 32'hFFFF_FFFF);
    $display("Reset and register map test done");

    foreach (rows[i]) begin
      apply(rows[i]);
      chk_out(rows[i].act_exp, rows[i].warn_exp, rows[i].flt_exp);
      rd_chk(sls_pkg::ADDR_STATUS, {31'h0, rows[i].act_exp}, "status bit");
      wr(sls_pkg::ADDR_EVENT, 32'h3);
    end
    $display("Compare mode table done");

    apply('{3'h2, 2'h3, 5'h03, 32'd200, 32'h0, 32'd100, 1, 0, 0});
    chk_out(1'b1, 1'b0, 1'b0);
    @(posedge i_clk_sys);
    i_running <= 1'b1;
    apply('{3'h2, 2'h3, 5'h03, 32'd200, 32'h0, 32'd100, 1, 0, 1});
    chk_out(1'b1, 1'b0, 1'b1);
    @(posedge i_clk_sys);
    i_running <= 1'b0;
    $display("Fault if running test done");

    // A new mask reaches the interrupt one edge after it is written
    wr(sls_pkg::ADDR_MASK, 32'h2);
    repeat (2) @(negedge i_clk_sys);
    chk({31'h0, o_irq}, 32'h1, "irq on masked-in fault");
    rd_chk(sls_pkg::ADDR_EVENT, 32'h2, "fault event bit");
    wr(sls_pkg::ADDR_EVENT, 32'h2);
    @(negedge i_clk_sys);
    chk({31'h0, o_irq}, 32'h0, "irq after clear");
    chk({31'h0, o_fault}, 32'h0, "fault after clear");
    apply('{3'h1, 2'h1, 5'h01, 32'hFFFF_FFFB, 32'h0, 32'h0, 1, 1, 0});
    chk({31'h0, o_irq}, 32'h0, "irq with warning masked out");
    rd_chk(sls_pkg::ADDR_EVENT, 32'h1, "warning event bit");
    wr(sls_pkg::ADDR_MASK, 32'h1);
    repeat (2) @(negedge i_clk_sys);
    chk({31'h0, o_irq}, 32'h1, "irq with warning masked in");
    wr(sls_pkg::ADDR_MASK, 32'h0);
    wr(sls_pkg::ADDR_EVENT, 32'h3);
    $display("Interrupt test done");

    // High limit 100, hysteresis 20: sets above 110, clears below 90
    wr(sls_pkg::ADDR_HYST, 32'd20);
    // Start the band from a released state
    apply('{3'h0, 2'h1, 5'h03, 32'd0, 32'h0, 32'd100, 0, 0, 0});
    chk_out(1'b0, 1'b0, 1'b0);
    apply('{3'h7, 2'h1, 5'h03, 32'd105, 32'h0, 32'd100, 0, 0, 0});
    chk_out(1'b0, 1'b0, 1'b0);
    apply('{3'h7, 2'h1, 5'h03, 32'd111, 32'h0, 32'd100, 1, 1, 0});
    chk_out(1'b1, 1'b1, 1'b0);
    apply('{3'h7, 2'h1, 5'h03, 32'd95, 32'h0, 32'd100, 1, 1, 0});
    chk_out(1'b1, 1'b1, 1'b0);
    apply('{3'h7, 2'h1, 5'h03, 32'd89, 32'h0, 32'd100, 0, 0, 0});
    chk_out(1'b0, 1'b0, 1'b0);
    $display("Hysteresis test done");

    apply('{3'h0, 2'h2, 5'h03, 32'd500, 32'h0, 32'd100, 0, 0, 0});
    chk_out(1'b0, 1'b0, 1'b0);
    $display("Disable test done");

    // Reset in mid-run with a latched, unmasked fault
    apply('{3'h2, 2'h2, 5'h03, 32'd500, 32'h0, 32'd100, 1, 0, 1});
    chk_out(1'b1, 1'b0, 1'b1);
    wr(sls_pkg::ADDR_MASK, 32'h2);
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(negedge i_clk_sys);
    chk_out(1'b0, 1'b0, 1'b0);
    chk({31'h0, o_irq}, 32'h0, "irq after second reset");
    rd_chk(sls_pkg::ADDR_CTRL, sls_pkg::CTRL_RESET, "control after second reset");
    rd_chk(sls_pkg::ADDR_MASK, 32'h0, "mask after second reset");
    rd_chk(sls_pkg::ADDR_EVENT, 32'h0, "event after second reset");
    $display("Second reset test done");
    results();
  end
endmodule : sls_supervisor_tb
`default_nettype wire
